// ---- rtl/pafn_pkg.sv ----
package pafn_pkg;
	// ------------------------------------------------------------
	// register byte offsets
	// ------------------------------------------------------------
	localparam logic [11:0] OFF_PA_DIR_HI  = 12'h000;
	localparam logic [11:0] OFF_PA_DIR_LO  = 12'h004;
	localparam logic [11:0] OFF_PA_FN_HI   = 12'h008;
	localparam logic [11:0] OFF_PA_FN_LO2  = 12'h00C;
	localparam logic [11:0] OFF_PA_FN_LO1  = 12'h010;
	localparam logic [11:0] OFF_PD_DIR_HI  = 12'h014;
	localparam logic [11:0] OFF_PD_FN_HI1  = 12'h018;
	localparam logic [11:0] OFF_PD_FN_HI2  = 12'h01C;
	// ------------------------------------------------------------
	// reset values and masks
	// ------------------------------------------------------------
	localparam logic [15:0] RST_REG        = 16'h0000;
	localparam logic [15:0] MASK_DIR_HI    = 16'h00FF;
	localparam logic [15:0] MASK_FN_HI     = 16'h5555;
	localparam logic [15:0] MASK_ALL       = 16'hFFFF;
	// ------------------------------------------------------------
	// pin function field layout
	// ------------------------------------------------------------
	localparam int          FN_W           = 2;
	localparam logic [1:0]  FN_PORT        = 2'h0;
	localparam int          PA_PINS        = 24;
	localparam int          PA_LO_PINS     = 16;
	localparam int          SERIAL_CLOCK_ZERO_PIN       = 2;
	localparam int          SERIAL_CLOCK_ONE_PIN       = 5;
	localparam int          PE_PINS        = 16;
	localparam int          JTAG_LO        = 8;
	localparam int          JTAG_HI        = 12;
	localparam logic [1:0]  SCK_FN_CODE    = 2'h1;
endpackage

// ---- rtl/pafn_regs_if.sv ----
`timescale 1ns/1ps
interface pafn_regs_if;
	logic [15:0] pa_dir_hi;
	logic [15:0] pa_dir_lo;
	logic [15:0] pa_fn_hi;
	logic [15:0] pa_fn_lo2;
	logic [15:0] pa_fn_lo1;
	modport regs (output pa_dir_hi, pa_dir_lo, pa_fn_hi, pa_fn_lo2, pa_fn_lo1);
	modport mux  (input  pa_dir_hi, pa_dir_lo, pa_fn_hi, pa_fn_lo2, pa_fn_lo1);
endinterface

// ---- rtl/pafn_dir_mux.sv ----
`timescale 1ns/1ps
module pafn_dir_mux #(
	parameter int PINS = 24
) (
	pafn_regs_if.mux         rg,
	input  wire logic [PINS-1:0] periph_oe,
	input  wire logic [PINS-1:0] sci_sck_io,
	output wire logic [PINS-1:0] pin_oe,
	output wire logic [PINS-1:0] pin_periph
);
	// ------------------------------------------------------------
	// function field per pin
	// ------------------------------------------------------------
	function automatic logic [1:0] pafn_field(input logic [47:0] fn,
		input int idx);
		pafn_field = fn[idx*2 +: 2];
	endfunction

	wire logic [47:0] fn_all = {rg.pa_fn_hi, rg.pa_fn_lo1, rg.pa_fn_lo2};
	wire logic [23:0] dir_all = {rg.pa_dir_hi[7:0], rg.pa_dir_lo};

	genvar g;
	generate
		for (g = 0; g < PINS; g++) begin : g_pin
			wire logic [1:0] fsel = pafn_field(fn_all, g);
			wire logic       is_port = (fsel == pafn_pkg::FN_PORT);
			// sck pins 2 and 5 follow the direction bit in serial mode too, when their sci_sck_io bit is set
			wire logic       use_dir = is_port ||
				((g == pafn_pkg::SERIAL_CLOCK_ZERO_PIN || g == pafn_pkg::SERIAL_CLOCK_ONE_PIN) &&
				 (fsel == pafn_pkg::SCK_FN_CODE) && sci_sck_io[g]);
			assign pin_periph[g] = !is_port;
			// direction bit or peripheral direction
			assign pin_oe[g] = use_dir ? dir_all[g] : periph_oe[g];
		end
	endgenerate
endmodule

// ---- rtl/pafn_top.sv ----
// The address map and the APB interface to the registers were decided locally.
`timescale 1ns/1ps
module pafn_top #(
	parameter bit LARGE_PKG = 1'b1
) (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	input  wire logic [3:0]  pstrb,
	output wire logic [31:0] prdata,
	output wire logic        pready,
	output wire logic        pslverr,
	input  wire logic [23:0] pa_periph_oe,
	input  wire logic [23:0] pa_sci_sck_io,
	output wire logic [23:0] pa_pin_oe,
	output wire logic [23:0] pa_pin_periph,
	input  wire logic        debug_mode_select,
	output wire logic [15:0] pe_jtag_force,
	output wire logic [15:0] port_d_high_direction,
	output wire logic [15:0] port_d_function_high_one,
	output wire logic [15:0] port_d_function_high_two
);
	// ------------------------------------------------------------
	// apb decode
	// ------------------------------------------------------------
	pafn_regs_if rif ();

	logic [15:0] pa_dir_hi_r;
	logic [15:0] pa_dir_lo_r;
	logic [15:0] pa_fn_hi_r;
	logic [15:0] pa_fn_lo2_r;
	logic [15:0] pa_fn_lo1_r;
	logic [15:0] pd_dir_hi_r;
	logic [15:0] pd_fn_hi1_r;
	logic [15:0] pd_fn_hi2_r;
	logic [31:0] prdata_r;
	logic        pslverr_r;
	logic        dbg_s1_r;
	logic        dbg_s2_r;

	wire logic acc = psel && penable;
	wire logic wr  = acc && pwrite;
	wire logic [15:0] wmask = {{8{pstrb[1]}}, {8{pstrb[0]}}};

	wire logic hit_pa_dh = (paddr == pafn_pkg::OFF_PA_DIR_HI);
	wire logic hit_pa_dl = (paddr == pafn_pkg::OFF_PA_DIR_LO);
	wire logic hit_pa_fh = (paddr == pafn_pkg::OFF_PA_FN_HI);
	wire logic hit_pa_f2 = (paddr == pafn_pkg::OFF_PA_FN_LO2);
	wire logic hit_pa_f1 = (paddr == pafn_pkg::OFF_PA_FN_LO1);
	wire logic hit_pd_dh = (paddr == pafn_pkg::OFF_PD_DIR_HI);
	wire logic hit_pd_f1 = (paddr == pafn_pkg::OFF_PD_FN_HI1);
	wire logic hit_pd_f2 = (paddr == pafn_pkg::OFF_PD_FN_HI2);
	wire logic hit_any = hit_pa_dh | hit_pa_dl | hit_pa_fh | hit_pa_f2 |
		hit_pa_f1 | hit_pd_dh | hit_pd_f1 | hit_pd_f2;

	// high registers exist only in the large package
	wire logic hi_ok = LARGE_PKG;
	wire logic [15:0] dh_mask =
		hi_ok ? pafn_pkg::MASK_DIR_HI : 16'h0000;
	wire logic [15:0] fh_mask =
		hi_ok ? pafn_pkg::MASK_FN_HI  : 16'h0000;
	wire logic [15:0] pd_mask =
		hi_ok ? pafn_pkg::MASK_ALL    : 16'h0000;

	// ------------------------------------------------------------
	// write merge
	// ------------------------------------------------------------
	function automatic logic [15:0] pafn_merge(input logic [15:0] old,
		input logic [15:0] wd, input logic [15:0] bm, input logic [15:0] fm);
		pafn_merge = ((old & ~bm) | (wd & bm)) & fm;
	endfunction

	wire logic [15:0] wd = pwdata[15:0];
	wire logic [15:0] pa_dir_hi_nxt = pafn_merge(pa_dir_hi_r, wd, wmask, dh_mask);
	wire logic [15:0] pa_dir_lo_nxt =
		pafn_merge(pa_dir_lo_r, wd, wmask, pafn_pkg::MASK_ALL);
	wire logic [15:0] pa_fn_hi_nxt = pafn_merge(pa_fn_hi_r, wd, wmask, fh_mask);
	wire logic [15:0] pa_fn_lo2_nxt =
		pafn_merge(pa_fn_lo2_r, wd, wmask, pafn_pkg::MASK_ALL);
	wire logic [15:0] pa_fn_lo1_nxt =
		pafn_merge(pa_fn_lo1_r, wd, wmask, pafn_pkg::MASK_ALL);
	wire logic [15:0] pd_dir_hi_nxt = pafn_merge(pd_dir_hi_r, wd, wmask, pd_mask);
	wire logic [15:0] pd_fn_hi1_nxt = pafn_merge(pd_fn_hi1_r, wd, wmask, pd_mask);
	wire logic [15:0] pd_fn_hi2_nxt = pafn_merge(pd_fn_hi2_r, wd, wmask, pd_mask);

	// ------------------------------------------------------------
	// registers
	// ------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pa_dir_hi_r <= pafn_pkg::RST_REG;
			pa_dir_lo_r <= pafn_pkg::RST_REG;
			pa_fn_hi_r  <= pafn_pkg::RST_REG;
			pa_fn_lo2_r <= pafn_pkg::RST_REG;
			pa_fn_lo1_r <= pafn_pkg::RST_REG;
			pd_dir_hi_r <= pafn_pkg::RST_REG;
			pd_fn_hi1_r <= pafn_pkg::RST_REG;
			pd_fn_hi2_r <= pafn_pkg::RST_REG;
		end else if (wr) begin
			if (hit_pa_dh) pa_dir_hi_r <= pa_dir_hi_nxt;
			if (hit_pa_dl) pa_dir_lo_r <= pa_dir_lo_nxt;
			if (hit_pa_fh) pa_fn_hi_r  <= pa_fn_hi_nxt;
			if (hit_pa_f2) pa_fn_lo2_r <= pa_fn_lo2_nxt;
			if (hit_pa_f1) pa_fn_lo1_r <= pa_fn_lo1_nxt;
			if (hit_pd_dh) pd_dir_hi_r <= pd_dir_hi_nxt;
			if (hit_pd_f1) pd_fn_hi1_r <= pd_fn_hi1_nxt;
			if (hit_pd_f2) pd_fn_hi2_r <= pd_fn_hi2_nxt;
		end
	end

	// ------------------------------------------------------------
	// read path
	// ------------------------------------------------------------
	wire logic [15:0] rsel =
		hit_pa_dh ? (pa_dir_hi_r & dh_mask) :
		hit_pa_dl ? pa_dir_lo_r :
		hit_pa_fh ? (pa_fn_hi_r & fh_mask) :
		hit_pa_f2 ? pa_fn_lo2_r :
		hit_pa_f1 ? pa_fn_lo1_r :
		hit_pd_dh ? pd_dir_hi_r :
		hit_pd_f1 ? pd_fn_hi1_r :
		hit_pd_f2 ? pd_fn_hi2_r : 16'h0000;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata_r  <= 32'h00000000;
			pslverr_r <= 1'b0;
		end else if (psel && !penable) begin
			prdata_r  <= {16'h0000, rsel};
			pslverr_r <= !hit_any;
		end
	end

	assign prdata  = prdata_r;
	assign pready  = 1'b1;
	assign pslverr = acc && pslverr_r;

	// ------------------------------------------------------------
	// debug select sync and jtag forcing
	// ------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			dbg_s1_r <= 1'b0;
			dbg_s2_r <= 1'b0;
		end else begin
			dbg_s1_r <= debug_mode_select;
			dbg_s2_r <= dbg_s1_r;
		end
	end

	genvar e;
	generate
		for (e = 0; e < pafn_pkg::PE_PINS; e++) begin : g_pe
			assign pe_jtag_force[e] = dbg_s2_r &&
				(e >= pafn_pkg::JTAG_LO) && (e <= pafn_pkg::JTAG_HI);
		end
	endgenerate

	// ------------------------------------------------------------
	// pin direction
	// ------------------------------------------------------------
	assign rif.pa_dir_hi = pa_dir_hi_r & dh_mask;
	assign rif.pa_dir_lo = pa_dir_lo_r;
	assign rif.pa_fn_hi  = pa_fn_hi_r & fh_mask;
	assign rif.pa_fn_lo2 = pa_fn_lo2_r;
	assign rif.pa_fn_lo1 = pa_fn_lo1_r;

	pafn_dir_mux #(
		.PINS (pafn_pkg::PA_PINS)
	) u_mux (
		.rg         (rif.mux),
		.periph_oe  (pa_periph_oe),
		.sci_sck_io (pa_sci_sck_io),
		.pin_oe     (pa_pin_oe),
		.pin_periph (pa_pin_periph)
	);

	assign port_d_high_direction    = pd_dir_hi_r;
	assign port_d_function_high_one = pd_fn_hi1_r;
	assign port_d_function_high_two = pd_fn_hi2_r;

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	property p_dir_out;
		@(posedge pclk) disable iff (!presetn)
		(pa_fn_lo2_r[1:0] == 2'h0) |-> (pa_pin_oe[0] == pa_dir_lo_r[0]);
	endproperty
	a_dir_out: assert property (p_dir_out) else $error("pin0 dir wrong");

	property p_periph;
		@(posedge pclk) disable iff (!presetn)
		(pa_fn_lo2_r[1:0] != 2'h0) && !pa_sci_sck_io[0] |->
			(pa_pin_oe[0] == pa_periph_oe[0]);
	endproperty
	a_periph: assert property (p_periph) else $error("periph dir");

	property p_dh_rsv;
		@(posedge pclk) disable iff (!presetn)
		wr && hit_pa_dh |=> (pa_dir_hi_r[15:8] == 8'h00);
	endproperty
	a_dh_rsv: assert property (p_dh_rsv) else $error("dir hi rsv");

	property p_fh_rsv;
		@(posedge pclk) disable iff (!presetn)
		wr && hit_pa_fh |=> ((pa_fn_hi_r & 16'hAAAA) == 16'h0000);
	endproperty
	a_fh_rsv: assert property (p_fh_rsv) else $error("fn hi rsv");

	property p_wr_lo;
		@(posedge pclk) disable iff (!presetn)
		wr && hit_pa_dl && (pstrb[1:0] == 2'h3) |=>
			(pa_dir_lo_r == $past(pwdata[15:0]));
	endproperty
	a_wr_lo: assert property (p_wr_lo) else $error("dir lo write");

	property p_small;
		@(posedge pclk) disable iff (!presetn)
		!LARGE_PKG |-> (pd_dir_hi_r == 16'h0000) && (pa_dir_hi_r == 16'h0000);
	endproperty
	a_small: assert property (p_small) else $error("small pkg hi");

	property p_jtag;
		@(posedge pclk) disable iff (!presetn)
		$rose(debug_mode_select) ##1 debug_mode_select[*2] |->
			(pe_jtag_force == 16'h1F00);
	endproperty
	a_jtag: assert property (p_jtag) else $error("jtag force");

	property p_hi_dir;
		@(posedge pclk) disable iff (!presetn)
		(pa_fn_hi_r[1:0] == 2'h0) |-> (pa_pin_oe[16] == rif.pa_dir_hi[0]);
	endproperty
	a_hi_dir: assert property (p_hi_dir) else $error("pin16 dir");

	// ------------------------------------------------------------
	// read path, serial clock, pin direction, debug and write checks
	// ------------------------------------------------------------
	property p_rd_lo;
		@(posedge pclk) disable iff (!presetn)
		psel && !penable && hit_pa_dl |=> (prdata[15:0] == pa_dir_lo_r);
	endproperty
	a_rd_lo: assert property (p_rd_lo) else $error("dir lo read");

	property p_rd_upper;
		@(posedge pclk) disable iff (!presetn)
		prdata[31:16] == 16'h0000;
	endproperty
	a_rd_upper: assert property (p_rd_upper) else $error("rd upper");

	property p_dh_read;
		@(posedge pclk) disable iff (!presetn)
		psel && !penable && hit_pa_dh |=> (prdata[15:8] == 8'h00);
	endproperty
	a_dh_read: assert property (p_dh_read) else $error("dir hi read");

	property p_fh_read;
		@(posedge pclk) disable iff (!presetn)
		psel && !penable && hit_pa_fh |=>
			((prdata[15:0] & 16'hAAAA) == 16'h0000);
	endproperty
	a_fh_read: assert property (p_fh_read) else $error("fn hi read");

	property p_sck2;
		@(posedge pclk) disable iff (!presetn)
		(pa_fn_lo2_r[5:4] == pafn_pkg::SCK_FN_CODE) && pa_sci_sck_io[2] |->
			(pa_pin_oe[2] == pa_dir_lo_r[2]);
	endproperty
	a_sck2: assert property (p_sck2) else $error("sck pin dir");

	property p_sck5;
		@(posedge pclk) disable iff (!presetn)
		(pa_fn_lo2_r[11:10] == pafn_pkg::SCK_FN_CODE) && !pa_sci_sck_io[5] |->
			(pa_pin_oe[5] == pa_periph_oe[5]);
	endproperty
	a_sck5: assert property (p_sck5) else $error("sck pin periph");

	property p_hi_periph;
		@(posedge pclk) disable iff (!presetn)
		(rif.pa_fn_hi[1:0] != 2'h0) |->
			(pa_pin_oe[16] == pa_periph_oe[16]);
	endproperty
	a_hi_periph: assert property (p_hi_periph) else $error("pin16 fn");

	property p_small_pins;
		@(posedge pclk) disable iff (!presetn)
		!LARGE_PKG |-> (pa_pin_oe[23:16] == 8'h00);
	endproperty
	a_small_pins: assert property (p_small_pins) else $error("small oe");

	property p_jtag_off;
		@(posedge pclk) disable iff (!presetn)
		!dbg_s2_r |-> (pe_jtag_force == 16'h0000);
	endproperty
	a_jtag_off: assert property (p_jtag_off) else $error("jtag off");

	property p_jtag_pins;
		@(posedge pclk) disable iff (!presetn)
		(pe_jtag_force & 16'hE0FF) == 16'h0000;
	endproperty
	a_jtag_pins: assert property (p_jtag_pins) else $error("jtag pins");

	property p_fn_lo1_wr;
		@(posedge pclk) disable iff (!presetn)
		wr && hit_pa_f1 && (pstrb[1:0] == 2'h3) |=>
			(pa_fn_lo1_r == $past(pwdata[15:0]));
	endproperty
	a_fn_lo1_wr: assert property (p_fn_lo1_wr) else $error("fn lo1 wr");

	property p_dl_keep;
		@(posedge pclk) disable iff (!presetn)
		!(wr && hit_pa_dl) |=> $stable(pa_dir_lo_r);
	endproperty
	a_dl_keep: assert property (p_dl_keep) else $error("dir lo kept");
endmodule

// ---- tb/tb_top.sv ----
`timescale 1ns/1ps
module tb_top;
	logic        pclk;
	logic        presetn;
	logic        psel;
	logic        penable;
	logic        pwrite;
	logic [11:0] paddr;
	logic [31:0] pwdata;
	logic [3:0]  pstrb;
	wire  [31:0] prdata;
	wire         pready;
	wire         pslverr;
	logic [23:0] pa_periph_oe;
	logic [23:0] pa_sci_sck_io;
	wire  [23:0] pa_pin_oe;
	wire  [23:0] pa_pin_periph;
	logic        debug_mode_select;
	wire  [15:0] pe_jtag_force;
	wire  [15:0] pd_dir;
	wire  [15:0] pd_fn1;
	wire  [15:0] pd_fn2;
	int          fail_count;
	int          checked;
	logic [31:0] rdat;
	logic        rerr;
	wire  [31:0] prdata_s;
	wire  [23:0] pin_oe_s;
	wire  [15:0] pd_dir_s;
	wire  [15:0] pd_fn1_s;

	pafn_top dut_u (
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
		.prdata(prdata), .pready(pready), .pslverr(pslverr),
		.pa_periph_oe(pa_periph_oe), .pa_sci_sck_io(pa_sci_sck_io),
		.pa_pin_oe(pa_pin_oe), .pa_pin_periph(pa_pin_periph),
		.debug_mode_select(debug_mode_select),
		.pe_jtag_force(pe_jtag_force),
		.port_d_high_direction(pd_dir),
		.port_d_function_high_one(pd_fn1),
		.port_d_function_high_two(pd_fn2)
	);

	pafn_top #(
		.LARGE_PKG (1'b0)
	) dut_small (
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
		.prdata(prdata_s), .pready(), .pslverr(),
		.pa_periph_oe(pa_periph_oe), .pa_sci_sck_io(pa_sci_sck_io),
		.pa_pin_oe(pin_oe_s), .pa_pin_periph(),
		.debug_mode_select(debug_mode_select),
		.pe_jtag_force(),
		.port_d_high_direction(pd_dir_s),
		.port_d_function_high_one(pd_fn1_s),
		.port_d_function_high_two()
	);

	// ------------------------------------------------------------
	// clock, compare and closing
	// ------------------------------------------------------------
	initial begin
		pclk = 1'b0;
		forever #25 pclk = ~pclk;
	end

	task chk(input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			fail_count++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task test_done;
		$display("checks %0d mismatches %0d", checked, fail_count);
		if (fail_count == 0 && checked > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	// ------------------------------------------------------------
	// apb master
	// ------------------------------------------------------------
	task apb(input logic w, input logic [11:0] a, input logic [15:0] d,
		input logic [3:0] s);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= w;
		paddr   <= a;
		pwdata  <= {16'h0000, d};
		pstrb   <= s;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		rdat = prdata;
		rerr = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask

	task wr(input logic [11:0] a, input logic [15:0] d);
		apb(1'b1, a, d, 4'h3);
	endtask

	task rd(input logic [11:0] a, input logic [31:0] exp);
		apb(1'b0, a, 16'h0000, 4'h0);
		chk(rdat, exp);
	endtask

	initial begin
		repeat (2000) @(posedge pclk);
		fail_count++;
		test_done;
	end

	// ------------------------------------------------------------
	// tests
	// ------------------------------------------------------------
	initial begin
		fail_count = 0;
		checked = 0;
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h000;
		pwdata = 32'h00000000;
		pstrb = 4'h0;
		pa_periph_oe = 24'h000000;
		pa_sci_sck_io = 24'h000000;
		debug_mode_select = 1'b0;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		chk({8'h00, pa_pin_oe}, 32'h00000000);
		for (int i = 0; i < 8; i++)
			rd(12'(4 * i), 32'h00000000);
		apb(1'b1, 12'h004, 16'hFFFF, 4'h1);
		rd(12'h004, 32'h000000FF);
		wr(12'h000, 16'hFFFF);
		rd(12'h000, 32'h000000FF);
		chk(prdata_s, 32'h00000000);
		wr(12'h008, 16'hFFFF);
		rd(12'h008, 32'h00005555);
		wr(12'h008, 16'h0000);
		wr(12'h014, 16'h1234);
		wr(12'h018, 16'h5678);
		wr(12'h01C, 16'h9ABC);
		chk({pd_dir, pd_fn1}, 32'h12345678);
		chk({16'h0000, pd_fn2}, 32'h00009ABC);
		chk({pd_dir_s, pd_fn1_s}, 32'h00000000);
		rd(12'h01C, 32'h00009ABC);
		wr(12'h020, 16'hFFFF);
		chk({31'h0, rerr}, 32'h00000001);
		rd(12'h020, 32'h00000000);
		wr(12'h004, 16'hA5A5);
		wr(12'h000, 16'h00C2);
		chk({8'h00, pa_pin_oe}, 32'h00C2A5A5);
		chk({8'h00, pin_oe_s}, 32'h0000A5A5);
		chk({8'h00, pa_pin_periph}, 32'h00000000);
		wr(12'h010, 16'h1357);
		rd(12'h010, 32'h00001357);
		wr(12'h010, 16'h0000);
		pa_periph_oe  <= 24'h010000;
		pa_sci_sck_io <= 24'h000024;
		wr(12'h00C, 16'h0411);
		wr(12'h008, 16'h0001);
		chk({8'h00, pa_pin_oe}, 32'h00C3A5A4);
		pa_sci_sck_io <= 24'h000000;
		@(posedge pclk);
		@(posedge pclk);
		chk({8'h00, pa_pin_oe}, 32'h00C3A580);
		chk({8'h00, pa_pin_periph}, 32'h00010025);
		debug_mode_select <= 1'b1;
		repeat (4) @(posedge pclk);
		chk({16'h0000, pe_jtag_force}, 32'h00001F00);
		debug_mode_select <= 1'b0;
		repeat (4) @(posedge pclk);
		chk({16'h0000, pe_jtag_force}, 32'h00000000);
		presetn <= 1'b0;
		@(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		rd(12'h004, 32'h00000000);
		chk({8'h00, pa_pin_oe}, 32'h00000000);
		test_done;
	end
endmodule
